//--- src/core_datapath_defs.vh
`ifndef CORE_DATAPATH_DEFS_VH
`define CORE_DATAPATH_DEFS_VH

// Bus register byte offsets.
`define OFF_CMD 8'h00
`define OFF_RESULT 8'h04
`define OFF_CORE 8'h08
`define OFF_CODE_DATA_POINTER 8'h0c
`define OFF_POWER 8'h10

// Command word fields.
`define CMD_OP 4:0
`define CMD_SRC 5
`define CMD_ADDR 15:8
`define CMD_IMM 23:16
`define CMD_W 24

// Command codes.
`define OP_NOP 5'h00
`define OP_ADD 5'h01
`define OP_ADDC 5'h02
`define OP_SUBB 5'h03
`define OP_ANL 5'h04
`define OP_ORL 5'h05
`define OP_XRL 5'h06
`define OP_MUL 5'h07
`define OP_DIV 5'h08
`define OP_RDDIR 5'h09
`define OP_WRDIR 5'h0a
`define OP_RDIND 5'h0b
`define OP_WRIND 5'h0c
`define OP_PUSH 5'h0d
`define OP_POP 5'h0e
`define OP_CODERD 5'h0f
`define OP_WRBIT 5'h10
`define OP_RDBIT 5'h11
`define OP_JADDR 5'h12
`define OP_LDACC 5'h13
`define OP_XDATA 5'h14

// Special function register addresses.
`define SFR_ACC 8'he0
`define SFR_B 8'hf0
`define SFR_PSW 8'hd0
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
`define SFR_PCON 8'h87
`define SFR_DFADDR 8'hc6
`define SFR_DFCTRL 8'hce
`define SFR_DFDATA 8'hcf

// Status word layout and reset values.
`define PSW_CY 7
`define PSW_AC 6
`define PSW_OV 2
`define PSW_RS 4:3
`define PSW_RST 8'h00
`define SP_RST 8'h07
`define BIT_AREA 8'h20
`define UNIMPL 8'hff

// Control bit positions.
`define DF_WR 0
`define DF_ERASE 1
`define PCON_IDLE 0
`define PCON_PD 1

// Code space map.
`define PROG_TOP 16'h1000
`define DF_TOP 16'h1080

`endif

//--- src/cpu_core_datapath.v
// Contract
// [RL1] 8-bit ALU sequenced by command decoder
// [RL2] Accumulator is primary operand and SFR
// [RL3] 8-bit second operand for multiply/divide
// [RL4] Status word holds ALU flags and bank
// [RL5] 128 bytes scratch-pad RAM, bit access
// [RL6] 8-bit stack pointer within scratch-pad RAM
// [RL7] 16-bit data pointer for code addressing
// [RL8] Code reads reach 4K program flash
// [RL9] Data flash 128 bytes, 16-byte pages
// [RL10] SFRs direct only; RAM direct and indirect
// [RL11] Upper half: SFR direct, nothing indirect
// [RL12] No external data memory space
// [RL13] Idle stops CPU clock, peripherals run
// [RL14] Power-down stops every clock
// [RL15] Four banks; R0/R1 are indirect pointers
// [RL16] Bytes 20h-2Fh bit addressable
// [RL17] Stack resets 07h, pre-increment push
// [RL18] Unimplemented SFRs and bits read one
// [RL19] Parity flag tracks accumulator parity
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "core_datapath_defs.vh"

module cpu_core_datapath (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Program flash read port, data in the same cycle as the address.
  output wire [11:0] progAddr,
  input wire [7:0] progData,
  // Power management.
  input wire wakeReq,
  output wire cpuClkEn,
  output wire periphClkEn
);

  localparam [2:0] PWR_RUN = 3'b001;
  localparam [2:0] PWR_IDLE = 3'b010;
  localparam [2:0] PWR_PD = 3'b100;

  reg [7:0] ram [0:127];
  reg [7:0] dflash [0:127];
  reg [7:0] acc_r, b_r, psw_r, sp_r, dfAddr_r, dfData_r;
  reg [15:0] code_data_pointer_r, result_r, codeAddr_r;
  reg [24:0] cmd_r;
  reg [2:0] pwr_r;
  reg codePend_r, wrPend_r, rdWait_r, wake1_r, wake2_r;
  reg [7:0] busAddr_r;

  wire accept = hsel & hready & htrans[1];
  wire [4:0] op = hwdata[`CMD_OP];
  wire [7:0] cAddr = hwdata[`CMD_ADDR];
  wire [7:0] cImm = hwdata[`CMD_IMM];
  wire exec = wrPend_r & hreadyout & (busAddr_r == `OFF_CMD) & pwr_r[0]; // [RL13] [RL14]
  wire parity = ^acc_r; // [RL19]
  wire [7:0] pswVal = {psw_r[7:1], parity};

  assign hreadyout = ~(rdWait_r | codePend_r);
  assign hresp = 1'b0;
  assign progAddr = codeAddr_r[11:0];
  assign cpuClkEn = pwr_r[0]; // [RL13]
  assign periphClkEn = ~pwr_r[2]; // [RL14]

  // Direct addressing: low half is RAM, high half only SFRs.
  function [7:0] dirRd;
    input [7:0] a;
    begin
      if (!a[7]) begin
        dirRd = ram[a[6:0]]; // [RL10] [RL11]
      end else begin
        case (a)
          `SFR_ACC: dirRd = acc_r; // [RL2]
          `SFR_B: dirRd = b_r; // [RL3]
          `SFR_PSW: dirRd = pswVal; // [RL4]
          `SFR_SP: dirRd = sp_r;
          `SFR_DPL: dirRd = code_data_pointer_r[7:0];
          `SFR_DPH: dirRd = code_data_pointer_r[15:8];
          `SFR_PCON: dirRd = {6'h3f, pwr_r[2], pwr_r[1]}; // [RL18]
          `SFR_DFADDR: dirRd = dfAddr_r;
          `SFR_DFDATA: dirRd = dfData_r;
          `SFR_DFCTRL: dirRd = 8'hfc; // [RL18]
          default: dirRd = `UNIMPL; // [RL18]
        endcase
      end
    end
  endfunction

  // Indirect addressing reaches RAM only; upper half is empty.
  function [7:0] indRd;
    input [7:0] a;
    begin
      indRd = a[7] ? `UNIMPL : ram[a[6:0]]; // [RL10] [RL11]
    end
  endfunction

  wire [7:0] opnd = hwdata[`CMD_SRC] ? dirRd(cAddr) : cImm;
  wire [7:0] riAddr = {3'h0, psw_r[`PSW_RS], 2'h0, cAddr[0]}; // [RL15]
  wire [7:0] riVal = ram[riAddr[6:0]];
  // Bit address: low half maps into 20h-2Fh, high half into SFRs ending in 0 or 8.
  wire [7:0] bitByte = cAddr[7] ? {cAddr[7:3], 3'h0} : (`BIT_AREA + {4'h0, cAddr[6:3]}); // [RL16]
  wire [7:0] bitOld = dirRd(bitByte);
  wire bitVal = bitOld[cAddr[2:0]];
  wire [7:0] spInc = sp_r + 8'h01;
  wire [7:0] spDec = sp_r - 8'h01;

  // Arithmetic unit.
  wire cin = (op == `OP_ADDC) & psw_r[`PSW_CY];
  wire [8:0] addSum = {1'b0, acc_r} + {1'b0, opnd} + {8'h00, cin}; // [RL1]
  wire [4:0] addNib = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  wire [8:0] subDif = {1'b0, acc_r} - {1'b0, opnd} - {8'h00, psw_r[`PSW_CY]};
  wire [4:0] subNib = {1'b0, acc_r[3:0]} - {1'b0, opnd[3:0]} - {4'h0, psw_r[`PSW_CY]};
  wire addOv = (acc_r[7] == opnd[7]) & (addSum[7] != acc_r[7]);
  wire subOv = (acc_r[7] != opnd[7]) & (subDif[7] != acc_r[7]);
  wire [15:0] prod = acc_r * b_r; // [RL3]
  wire divZero = (b_r == 8'h00);
  // Guarded divisor keeps the divider free of unknowns; the result is discarded on zero.
  wire [7:0] divisor = divZero ? 8'h01 : b_r;
  wire [7:0] quot = acc_r / divisor;
  wire [7:0] remd = acc_r % divisor;
  wire [15:0] jumpAddr = code_data_pointer_r + {8'h00, acc_r}; // [RL1] [RL7]

  // One memory write per command.
  reg memWe, memInd;
  reg [7:0] memAddr, memData;
  always @* begin
    memWe = 1'b0;
    memInd = 1'b0;
    memAddr = cAddr;
    memData = cImm;
    if (exec) begin
      case (op)
        `OP_WRDIR: begin
          memWe = 1'b1;
        end
        `OP_WRIND: begin
          memWe = 1'b1;
          memInd = 1'b1;
          memAddr = riVal; // [RL15]
        end
        `OP_PUSH: begin
          memWe = 1'b1;
          memInd = 1'b1;
          memAddr = spInc; // [RL17] [RL6]
          memData = dirRd(cAddr);
        end
        `OP_POP: begin
          memWe = 1'b1;
          memData = indRd(sp_r); // [RL17] [RL6]
        end
        `OP_WRBIT: begin
          memWe = 1'b1;
          memAddr = bitByte; // [RL16]
          memData = bitOld;
          memData[cAddr[2:0]] = cImm[0];
        end
        default: begin
          memWe = 1'b0;
        end
      endcase
    end
  end

  wire ramWe = memWe & ~memAddr[7]; // [RL11]
  wire sfrWe = memWe & memAddr[7] & ~memInd; // [RL10]
  wire dfWr = sfrWe & (memAddr == `SFR_DFCTRL) & memData[`DF_WR];
  wire dfErase = sfrWe & (memAddr == `SFR_DFCTRL) & memData[`DF_ERASE];

  always @(posedge core_clk) begin
    if (ramWe) begin
      ram[memAddr[6:0]] <= memData; // [RL5]
    end
  end

  // Data flash: byte write from the staging registers, or erase of one 16-byte page.
  genvar g;
  generate
    for (g = 0; g < 128; g = g + 1) begin : dfCell
      localparam [6:0] IDX = g;
      always @(posedge core_clk) begin
        if (dfErase && dfAddr_r[6:4] == IDX[6:4]) begin
          dflash[g] <= `UNIMPL; // [RL9]
        end else if (dfWr && dfAddr_r[6:0] == IDX) begin
          dflash[g] <= dfData_r; // [RL9]
        end
      end
    end
  endgenerate

  // Code space: program flash, then data flash, then nothing.
  wire [7:0] codeVal = (codeAddr_r < `PROG_TOP) ? progData : // [RL8]
    ((codeAddr_r < `DF_TOP) ? dflash[codeAddr_r[6:0]] : `UNIMPL); // [RL9]

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake1_r <= 1'b0;
      wake2_r <= 1'b0;
    end else begin
      wake1_r <= wakeReq;
      wake2_r <= wake1_r;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_r <= 8'h00;
      b_r <= 8'h00;
      psw_r <= `PSW_RST;
      sp_r <= `SP_RST; // [RL17]
      code_data_pointer_r <= 16'h0000;
      dfAddr_r <= 8'h00;
      dfData_r <= 8'h00;
      result_r <= 16'h0000;
      codeAddr_r <= 16'h0000;
      codePend_r <= 1'b0;
      pwr_r <= PWR_RUN;
    end else begin
      codePend_r <= 1'b0;
      if (codePend_r) begin
        acc_r <= codeVal; // [RL8] [RL9]
        result_r <= {8'h00, codeVal};
      end
      if (exec) begin
        case (op)
          `OP_ADD, `OP_ADDC: begin
            acc_r <= addSum[7:0]; // [RL1]
            psw_r[`PSW_CY] <= addSum[8]; // [RL4]
            psw_r[`PSW_AC] <= addNib[4];
            psw_r[`PSW_OV] <= addOv;
          end
          `OP_SUBB: begin
            acc_r <= subDif[7:0];
            psw_r[`PSW_CY] <= subDif[8]; // [RL4]
            psw_r[`PSW_AC] <= subNib[4];
            psw_r[`PSW_OV] <= subOv;
          end
          `OP_ANL: acc_r <= acc_r & opnd; // [RL2]
          `OP_ORL: acc_r <= acc_r | opnd;
          `OP_XRL: acc_r <= acc_r ^ opnd;
          `OP_LDACC: acc_r <= opnd;
          `OP_MUL: begin
            acc_r <= prod[7:0]; // [RL3]
            b_r <= prod[15:8];
            psw_r[`PSW_CY] <= 1'b0;
            psw_r[`PSW_OV] <= |prod[15:8];
          end
          `OP_DIV: begin
            psw_r[`PSW_CY] <= 1'b0;
            psw_r[`PSW_OV] <= divZero; // [RL3]
            if (!divZero) begin
              acc_r <= quot;
              b_r <= remd;
            end
          end
          `OP_RDDIR: result_r <= {8'h00, dirRd(cAddr)}; // [RL10]
          `OP_RDIND: result_r <= {8'h00, indRd(riVal)}; // [RL15] [RL11]
          `OP_RDBIT: result_r <= {15'h0000, bitVal}; // [RL16]
          `OP_JADDR: result_r <= jumpAddr; // [RL1]
          `OP_XDATA: result_r <= {8'h00, `UNIMPL}; // [RL12]
          `OP_PUSH: sp_r <= spInc; // [RL17]
          `OP_POP: begin
            sp_r <= spDec; // [RL17]
            result_r <= {8'h00, memData};
          end
          `OP_CODERD: begin
            codeAddr_r <= jumpAddr; // [RL7] [RL9]
            codePend_r <= 1'b1;
          end
          default: begin
            result_r <= result_r;
          end
        endcase
      end
      // Direct SFR writes land last, so a pop into SP keeps the popped value.
      if (sfrWe) begin
        case (memAddr)
          `SFR_ACC: acc_r <= memData; // [RL2]
          `SFR_B: b_r <= memData; // [RL3]
          `SFR_PSW: psw_r <= {memData[7:1], 1'b0}; // [RL19]
          `SFR_SP: sp_r <= memData; // [RL6]
          `SFR_DPL: code_data_pointer_r[7:0] <= memData; // [RL7]
          `SFR_DPH: code_data_pointer_r[15:8] <= memData;
          `SFR_DFADDR: dfAddr_r <= memData; // [RL9]
          `SFR_DFDATA: dfData_r <= memData;
          default: dfData_r <= dfData_r;
        endcase
      end
      case (pwr_r)
        PWR_RUN: begin
          if (sfrWe && memAddr == `SFR_PCON && memData[`PCON_PD]) begin
            pwr_r <= PWR_PD; // [RL14]
          end else if (sfrWe && memAddr == `SFR_PCON && memData[`PCON_IDLE]) begin
            pwr_r <= PWR_IDLE; // [RL13]
          end
        end
        PWR_IDLE, PWR_PD: begin
          if (wake2_r) begin
            pwr_r <= PWR_RUN;
          end
        end
        default: pwr_r <= PWR_RUN;
      endcase
    end
  end

  // Bus side: writes finish with zero wait, one right behind a code read; reads hold one wait state, two right behind a code read, to see the latest state.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      rdWait_r <= 1'b0;
      busAddr_r <= 8'h00;
      cmd_r <= 25'h0000000;
      hrdata <= 32'h00000000;
    end else begin
      if (wrPend_r && hreadyout && busAddr_r == `OFF_CMD) begin
        cmd_r <= {exec, hwdata[23:0]};
      end
      if (rdWait_r && !codePend_r) begin
        rdWait_r <= 1'b0;
        case (busAddr_r)
          `OFF_CMD: hrdata <= {7'h00, cmd_r};
          `OFF_RESULT: hrdata <= {16'h0000, result_r};
          `OFF_CORE: hrdata <= {sp_r, pswVal, b_r, acc_r};
          `OFF_CODE_DATA_POINTER: hrdata <= {16'h0000, code_data_pointer_r};
          `OFF_POWER: hrdata <= {29'h00000000, pwr_r};
          default: hrdata <= 32'h00000000;
        endcase
      end
      if (accept) begin
        wrPend_r <= hwrite;
        rdWait_r <= ~hwrite;
        busAddr_r <= haddr[7:0];
      end else if (hreadyout) begin
        wrPend_r <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/core_datapath_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module core_datapath_asserts (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Bus slave side.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Power management.
  input wire logic wakeReq,
  input wire logic cpuClkEn,
  input wire logic periphClkEn
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rdTaken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  // Four quiet samples cover the two-flop wake synchroniser and the state flop.
  sequence wakeQuiet;
    !wakeReq [*4];
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rdTaken |=> !hreadyout)
    else $error("read answered without a wait state");
  a_wait_bound: assert property (rdTaken |=> ##[1:2] hreadyout)
    else $error("read answer late");
  a_wait_short: assert property (!hreadyout ##1 !hreadyout |=> hreadyout)
    else $error("wait state too long");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data changed outside a read");
  a_pd_gates_cpu: assert property (!periphClkEn |-> !cpuClkEn)
    else $error("cpu clock runs in power-down");
  a_pd_holds: assert property (wakeQuiet ##0 !periphClkEn |=> !periphClkEn)
    else $error("power-down left without wake");
  a_idle_holds: assert property (wakeQuiet ##0 !cpuClkEn |=> !cpuClkEn)
    else $error("cpu clock resumed without wake");
  a_wake_resume: assert property (wakeReq [*4] |-> cpuClkEn && periphClkEn)
    else $error("wake did not resume clocks");
endmodule
bind cpu_core_datapath core_datapath_asserts i_asserts (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .wakeReq(wakeReq), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn));
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "core_datapath_defs.vh"
module tb_top;
  logic core_clk = 0, rst = 1, hwrite = 0, wakeReq = 0, rdPhase = 0, hreadyout, hresp, cpuClkEn, periphClkEn;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [11:0] progAddr;
  logic [7:0] a, b;
  logic [8:0] s;
  logic [15:0] p;
  logic [2:0] fl = 0;
  logic [31:0] expQ[$];
  int num_errors = 0, samples_checked = 0;
  // Program flash stand-in: all twelve address bits fold into the data, so a stale or cut address shows.
  wire [7:0] progData = progAddr[7:0] ^ {progAddr[11:8], 4'ha};
  always #5 core_clk = ~core_clk;
  cpu_core_datapath i_dut (.core_clk(core_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .progAddr(progAddr), .progData(progData), .wakeReq(wakeReq),
    .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge core_clk) begin
    if (rdPhase && hreadyout) chk(hrdata, expQ.pop_front());
    if (htrans[1] && !hwrite && hreadyout) rdPhase <= 1'b1;
    else if (hreadyout) rdPhase <= 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= w;
    @(posedge core_clk);
    while (!hreadyout) @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (!hreadyout) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    expQ.push_back(e);
    xfer(1'b0, ad, 32'h0);
  endtask
  task automatic ex(input logic [4:0] op, input logic [7:0] ad, input logic [7:0] im);
    xfer(1'b1, `OFF_CMD, {8'h00, im, ad, 3'h0, op});
  endtask
  task automatic rdd(input logic [7:0] ad, input logic [15:0] e);
    ex(`OP_RDDIR, ad, 8'h00);
    rd(`OFF_RESULT, {16'h0, e});
  endtask
  task automatic wake;
    wakeReq <= 1'b1;
    repeat (4) @(posedge core_clk);
    wakeReq <= 1'b0;
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h2317));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(`OFF_CORE, 32'h07000000);
    for (int i = 1; i < 7; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      ex(`OP_LDACC, 8'h00, a);
      ex(i[4:0], 8'h00, b);
      case (i)
        1, 2: s = a + b + (i == 2 && fl[2]);
        3: s = {1'b0, a} - b - fl[2];
        4: s = a & b;
        5: s = a | b;
        default: s = a ^ b;
      endcase
      if (i < 3) fl = {s[8], (a[3:0] + b[3:0] + (i == 2 && fl[2])) > 5'h0f, a[7] == b[7] && s[7] != a[7]};
      if (i == 3) fl = {s[8], a[3:0] < {1'b0, b[3:0]} + fl[2], a[7] != b[7] && s[7] != a[7]};
      rd(`OFF_CORE, {8'h07, fl[2:1], 3'h0, fl[0], 1'b0, ^s[7:0], 8'h00, s[7:0]});
    end
    p = s[7:0] * b;
    ex(`OP_WRDIR, `SFR_B, b);
    ex(`OP_MUL, 8'h00, 8'h00);
    rdd(`SFR_ACC, p[7:0]);
    rdd(`SFR_B, p[15:8]);
    ex(`OP_LDACC, 8'h00, a);
    ex(`OP_WRDIR, `SFR_B, b | 8'h01);
    ex(`OP_DIV, 8'h00, 8'h00);
    rdd(`SFR_B, a % (b | 8'h01));
    ex(`OP_WRDIR, `SFR_B, 8'h00);
    ex(`OP_DIV, 8'h00, 8'h00);
    rdd(`SFR_ACC, a / (b | 8'h01));
    ex(`OP_RDBIT, 8'hd2, 8'h00);
    rd(`OFF_RESULT, 32'h1);
    ex(`OP_WRDIR, 8'h00, 8'h30);
    ex(`OP_WRDIR, 8'h30, a);
    ex(`OP_RDIND, 8'h00, 8'h00);
    rd(`OFF_RESULT, {24'h0, a});
    ex(`OP_WRDIR, `SFR_PSW, 8'h08);
    ex(`OP_WRDIR, 8'h08, 8'h90);
    ex(`OP_WRIND, 8'h00, b);
    ex(`OP_RDIND, 8'h00, 8'h00);
    rd(`OFF_RESULT, 32'hff);
    rdd(8'h90, 16'h00ff);
    rdd(8'h00, 16'h0030);
    ex(`OP_WRDIR, 8'h7f, b);
    rdd(8'h7f, {8'h00, b});
    ex(`OP_WRDIR, 8'h21, 8'h00);
    ex(`OP_WRBIT, 8'h0b, 8'h01);
    rdd(8'h21, 16'h0008);
    ex(`OP_PUSH, 8'h30, 8'h00);
    rdd(`SFR_SP, 16'h0008);
    rdd(8'h08, {8'h00, a});
    xfer(1'b1, `OFF_CMD, {8'h00, 16'h0008, 3'h1, `OP_LDACC});
    rdd(`SFR_ACC, {8'h00, a});
    ex(`OP_POP, 8'h31, 8'h00);
    rd(`OFF_RESULT, {24'h0, a});
    rdd(`SFR_SP, 16'h0007);
    ex(`OP_WRDIR, `SFR_DPL, 8'h34);
    ex(`OP_WRDIR, `SFR_DPH, 8'h02);
    ex(`OP_LDACC, 8'h00, 8'h10);
    ex(`OP_JADDR, 8'h00, 8'h00);
    rd(`OFF_RESULT, 32'h0244);
    rd(`OFF_CODE_DATA_POINTER, 32'h0234);
    ex(`OP_CODERD, 8'h00, 8'h00);
    rdd(`SFR_ACC, 16'h006e);
    ex(`OP_WRDIR, `SFR_DFADDR, 8'h25);
    ex(`OP_WRDIR, `SFR_DFCTRL, 8'h02);
    ex(`OP_WRDIR, `SFR_DFDATA, b);
    ex(`OP_WRDIR, `SFR_DFCTRL, 8'h01);
    ex(`OP_WRDIR, `SFR_DPL, 8'h00);
    ex(`OP_WRDIR, `SFR_DPH, 8'h10);
    for (int i = 0; i < 2; i++) begin
      ex(`OP_LDACC, 8'h00, i ? 8'h2f : 8'h25);
      ex(`OP_CODERD, 8'h00, 8'h00);
      rdd(`SFR_ACC, i ? 16'h00ff : {8'h00, b});
    end
    ex(`OP_XDATA, 8'h00, 8'h00);
    rd(`OFF_RESULT, 32'h00ff);
    rd(`OFF_CMD, 32'h01000014);
    xfer(1'b1, 8'h14, $urandom);
    rd(8'h14, 32'h0);
    ex(`OP_WRDIR, `SFR_PCON, 8'h01);
    rd(`OFF_POWER, 32'h2);
    chk({30'h0, cpuClkEn, periphClkEn}, 32'h1);
    ex(`OP_LDACC, 8'h00, 8'h77);
    rd(`OFF_CMD, 32'h00770013);
    wake();
    ex(`OP_WRDIR, `SFR_PCON, 8'h02);
    rd(`OFF_POWER, 32'h4);
    chk({30'h0, cpuClkEn, periphClkEn}, 32'h0);
    wake();
    rd(`OFF_POWER, 32'h1);
    rdd(`SFR_ACC, 16'h00ff);
    wrap_up();
  end
endmodule
`default_nettype wire
